// *** src/csi_pkg.sv ***
// constants shared by the clocked serial interface
package csi_pkg;
   // register addresses
   localparam logic [15:0] ADDR_PULLUP = 16'hff45;
   localparam logic [15:0] ADDR_TRIG = 16'hff70;
   localparam logic [15:0] ADDR_MODE = 16'hff71;
   localparam logic [15:0] ADDR_DATA_LO = 16'hff72;
   localparam logic [15:0] ADDR_DATA_HI = 16'hff73;
   localparam logic [15:0] ADDR_IRQ_EN = 16'hffe3;
   localparam logic [15:0] ADDR_IRQ_FLAG = 16'hfff3;
   // field positions
   localparam int BIT_PORT_EN = 0;
   localparam int BIT_TRIGGER = 1;
   localparam int BIT_ORDER = 3;
   localparam int BIT_SAMPLE = 2;
   localparam int BIT_IRQ = 0;
   localparam int BIT_PU_RX = 0;
   localparam int BIT_PU_CLK = 2;
   localparam int BIT_SRC_HI = 1;
   localparam int BIT_SRC_LO = 0;
   // reset values
   localparam logic [3:0] RST_PULLUP = 4'hf;
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] READ_ZERO = 4'h0;
   // clock source select encodings
   localparam logic [1:0] CSS_LOW_SPEED_OSC = 2'h3;
   localparam logic [1:0] CSS_LOW_SPEED_OSC_DIV2 = 2'h2;
   localparam logic [1:0] CSS_TIMER = 2'h1;
   localparam logic [1:0] CSS_EXTERNAL = 2'h0;
   // bits per transfer
   localparam logic [3:0] BITS_PER_XFER = 4'h8;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   // transfer state
   typedef enum logic {
      ST_STOP = 1'b0,
      ST_RUN = 1'b1
   } csi_state_t;
endpackage

// *** src/csi_top.sv ***
// clocked serial interface: registers, shift clock and shifter
// Notes on behaviour
// RULE_01 - two-bit select picks shift clock source
// RULE_02 - timer source is underflow divided by two
// RULE_03 - reset selects external clock, slave mode
// RULE_04 - shift clock at most 1 MHz
// RULE_05 - sample edge bit picks capture edge
// RULE_06 - output changes on fixed edge only
// RULE_07 - bit order bit sets MSB/LSB first
// RULE_08 - set bit order before loading data
// RULE_09 - writing 1 triggers, 0 ignored
// RULE_10 - enable port and touch data first
// RULE_11 - data access arms the trigger circuit
// RULE_12 - trigger only once per transfer
// RULE_13 - slave clock starts after trigger
// RULE_14 - trigger reads 1 until eight clocks
// RULE_15 - data bits shifted out on output pin
// RULE_16 - received bits assembled into data bits
// RULE_17 - data access only while stopped
// RULE_18 - flag set after each byte, even masked
// RULE_19 - writing 1 clears the flag
// RULE_20 - enable bit allows or masks interrupt
// RULE_21 - service routine clears flag before return
// RULE_22 - pull-up bits reset to 1
// RULE_23 - port enable gives pins serial functions
// RULE_24 - slave-ready output only in slave mode
// RULE_25 - request when flag and enable set
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module csi_top
   import csi_pkg::*;
#(
   parameter bit POS_POLARITY = 1'b0
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [3:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [3:0] reg_rdata_o,
   input wire logic low_speed_osc_edge_i,
   input wire logic timer_uf_i,
   input wire logic serial_in_pin_i,
   output logic serial_out_pin_o,
   output logic serial_out_pin_oe_o,
   input wire logic shift_clk_i,
   output logic shift_clk_o,
   output logic shift_clk_oe_o,
   output logic slave_ready_out_n_o,
   output logic slave_ready_out_oe_o,
   output logic rx_pin_pullup_o,
   output logic clock_pin_pullup_o,
   output logic serial_port_enable_o,
   output logic serial_irq_o
);
   // idle level of the clock line depends on the polarity option
   // fixed per build, so software has no way to read it back
   localparam logic IDLE_LEVEL = ~POS_POLARITY;

   logic [3:0] pullup_reg;
   logic serial_port_enable_reg;
   logic clock_source_select_hi_reg;
   logic clock_source_select_lo_reg;
   logic sample_edge_select_reg;
   logic bit_order_select_reg;
   logic [7:0] shift_data_reg;
   logic serial_irq_enable_reg;
   logic serial_irq_flag_reg;
   logic armed_reg;
   csi_state_t state_reg;
   logic [7:0] tx_reg;
   logic [7:0] rx_reg;
   logic [3:0] cnt_reg;
   logic first_reg;
   logic sclk_reg;
   logic div2_reg;
   logic ext_prev_reg;
   logic [3:0] rdata_reg;

   logic master;
   logic running;
   logic data_acc;
   logic trig_wr;
   logic tick;
   logic edge_ev;
   logic edge_rise;
   logic open_edge;
   logic close_edge;
   logic sample_now;
   logic done;

   // address compare shared by every register decode except the read mux
   function automatic logic hit(input logic [15:0] a);
      hit = (reg_addr_i == a);
   endfunction

   // any nonzero source select means this side drives the clock
   assign master = clock_source_select_hi_reg | clock_source_select_lo_reg;
   assign running = (state_reg == ST_RUN);
   assign data_acc = (reg_wr_i | reg_rd_i) &
      (hit(ADDR_DATA_LO) | hit(ADDR_DATA_HI));
   // RULE_09 write one triggers
   assign trig_wr = reg_wr_i & hit(ADDR_TRIG) & reg_wdata_i[BIT_TRIGGER];

   // RULE_22 pull-ups, reset on
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pullup_reg <= RST_PULLUP;
      end else if (reg_wr_i && hit(ADDR_PULLUP)) begin
         pullup_reg <= reg_wdata_i;
      end
   end

   // port enable and mode bits
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         serial_port_enable_reg <= 1'b0;
         // RULE_03 external clock at reset
         clock_source_select_hi_reg <= 1'b0;
         clock_source_select_lo_reg <= 1'b0;
         sample_edge_select_reg <= 1'b0;
         bit_order_select_reg <= 1'b0;
         serial_irq_enable_reg <= 1'b0;
      end else begin
         if (reg_wr_i && hit(ADDR_TRIG)) begin
            serial_port_enable_reg <= reg_wdata_i[BIT_PORT_EN];
         end
         if (reg_wr_i && hit(ADDR_MODE)) begin
            clock_source_select_hi_reg <= reg_wdata_i[BIT_SRC_HI];
            clock_source_select_lo_reg <= reg_wdata_i[BIT_SRC_LO];
            sample_edge_select_reg <= reg_wdata_i[BIT_SAMPLE];
            bit_order_select_reg <= reg_wdata_i[BIT_ORDER];
         end
         // RULE_20 interrupt enable bit
         if (reg_wr_i && hit(ADDR_IRQ_EN)) begin
            serial_irq_enable_reg <= reg_wdata_i[BIT_IRQ];
         end
      end
   end

   // a refused trigger while stopped drops the arm too, so software
   // touches the data again; cheaper than tracking why it was refused
   // RULE_11 data access arms trigger
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         armed_reg <= 1'b0;
      end else if (trig_wr && !running) begin
         armed_reg <= 1'b0;
      end else if (data_acc) begin
         armed_reg <= 1'b1;
      end
   end

   // source change in mid-byte not guarded, software keeps it still
   // RULE_01 source select, master tick
   always_comb begin
      case ({clock_source_select_hi_reg, clock_source_select_lo_reg})
         CSS_LOW_SPEED_OSC: tick = low_speed_osc_edge_i;
         CSS_LOW_SPEED_OSC_DIV2: tick = low_speed_osc_edge_i & div2_reg;
         // RULE_02 timer underflow halved by toggle
         CSS_TIMER: tick = timer_uf_i;
         default: tick = 1'b0;
      endcase
   end

   // halves the oscillator edge rate for the divided source
   // free running, so the first divided tick may come an edge late
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         div2_reg <= 1'b0;
      end else if (low_speed_osc_edge_i) begin
         div2_reg <= ~div2_reg;
      end
   end

   // master clock toggles once per tick while running
   // forced to idle when stopped, so a mode change never leaves
   // the line half way through a bit
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sclk_reg <= IDLE_LEVEL;
      end else if (!running || !master) begin
         sclk_reg <= IDLE_LEVEL;
      end else if (tick) begin
         sclk_reg <= ~sclk_reg;
      end
   end

   // previous external level, watched only in slave mode
   // no synchroniser: the pin is taken as synchronous to mclk_i
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ext_prev_reg <= IDLE_LEVEL;
      end else begin
         ext_prev_reg <= shift_clk_i;
      end
   end

   // edge events of the shift clock, master or slave
   // slave edges are seen one cycle late, so the partner clock
   // must stay far below the system clock
   always_comb begin
      if (master) begin
         edge_ev = running & tick;
         edge_rise = ~sclk_reg;
      end else begin
         // RULE_13 edges ignored until triggered
         edge_ev = running & (shift_clk_i ^ ext_prev_reg);
         edge_rise = shift_clk_i;
      end
   end

   // RULE_06 output edge leaves idle level
   assign open_edge = edge_ev & (edge_rise == POS_POLARITY);
   assign close_edge = edge_ev & (edge_rise != POS_POLARITY);
   // RULE_05 capture edge per sample bit
   assign sample_now = edge_ev &
      (edge_rise == (POS_POLARITY ? sample_edge_select_reg
                                  : ~sample_edge_select_reg));
   // eighth return to idle, counting from zero
   assign done = close_edge && (cnt_reg == BITS_PER_XFER - CNT_ONE);

   // transfer state
   // a trigger while running is ignored rather than restarting the byte
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state_reg <= ST_STOP;
      end else begin
         case (state_reg)
            ST_STOP: begin
               // RULE_10 needs enable and arming
               if (trig_wr && armed_reg && serial_port_enable_reg) begin
                  state_reg <= ST_RUN;
               end
            end
            ST_RUN: begin
               // RULE_14 status clears after eight clocks
               if (done) begin
                  state_reg <= ST_STOP;
               end
            end
            default: state_reg <= ST_STOP;
         endcase
      end
   end

   // completed clock count and first output edge marker
   // first opening edge must not shift: the first bit already stands
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cnt_reg <= CNT_ZERO;
         first_reg <= 1'b1;
      end else if (!running) begin
         cnt_reg <= CNT_ZERO;
         first_reg <= 1'b1;
      end else begin
         if (close_edge) begin
            cnt_reg <= cnt_reg + CNT_ONE;
         end
         if (open_edge) begin
            first_reg <= 1'b0;
         end
      end
   end

   // transmit shifter: first bit stands from trigger onward
   // reloaded in every stopped cycle, so the pin shows the new first
   // bit as soon as software writes the data
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tx_reg <= RST_BYTE;
      end else if (!running) begin
         tx_reg <= shift_data_reg;
      end else if (open_edge && !first_reg) begin
         // RULE_07 direction from order bit
         if (bit_order_select_reg) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
         end else begin
            tx_reg <= {1'b0, tx_reg[7:1]};
         end
      end
   end

   // receive shifter
   // idle noise on the input is ignored while stopped
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rx_reg <= RST_BYTE;
      end else if (running && sample_now) begin
         if (bit_order_select_reg) begin
            rx_reg <= {rx_reg[6:0], serial_in_pin_i};
         end else begin
            rx_reg <= {serial_in_pin_i, rx_reg[7:1]};
         end
      end
   end

   // data register: software writes, received byte at the end
   // the end of a byte beats a write, which software must not make then
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         shift_data_reg <= RST_BYTE;
      end else if (done) begin
         // RULE_16 received byte loaded; last bit may land now
         if (sample_now && bit_order_select_reg) begin
            shift_data_reg <= {rx_reg[6:0], serial_in_pin_i};
         end else if (sample_now) begin
            shift_data_reg <= {serial_in_pin_i, rx_reg[7:1]};
         end else begin
            shift_data_reg <= rx_reg;
         end
      end else if (reg_wr_i && hit(ADDR_DATA_LO)) begin
         shift_data_reg[3:0] <= reg_wdata_i;
      end else if (reg_wr_i && hit(ADDR_DATA_HI)) begin
         shift_data_reg[7:4] <= reg_wdata_i;
      end
   end

   // a clear on the completing cycle is lost, so no event is missed
   // RULE_18 flag on each byte; set beats clear
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         serial_irq_flag_reg <= 1'b0;
      end else if (done) begin
         serial_irq_flag_reg <= 1'b1;
      end else if (reg_wr_i && hit(ADDR_IRQ_FLAG) &&
                   reg_wdata_i[BIT_IRQ]) begin
         // RULE_19 write one clears
         serial_irq_flag_reg <= 1'b0;
      end
   end

   // read data stands one cycle after the read strobe
   // unused trigger and interrupt bits and unmapped addresses read back as zero; all four pull-up bits read back as written
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rdata_reg <= READ_ZERO;
      end else if (!reg_rd_i) begin
         rdata_reg <= READ_ZERO;
      end else begin
         case (reg_addr_i)
            ADDR_PULLUP: rdata_reg <= pullup_reg;
            ADDR_TRIG: rdata_reg <= {2'b00, running, serial_port_enable_reg};
            ADDR_MODE: rdata_reg <= {bit_order_select_reg,
               sample_edge_select_reg, clock_source_select_hi_reg,
               clock_source_select_lo_reg};
            ADDR_DATA_LO: rdata_reg <= shift_data_reg[3:0];
            ADDR_DATA_HI: rdata_reg <= shift_data_reg[7:4];
            ADDR_IRQ_EN: rdata_reg <= {3'b000, serial_irq_enable_reg};
            ADDR_IRQ_FLAG: rdata_reg <= {3'b000, serial_irq_flag_reg};
            default: rdata_reg <= READ_ZERO;
         endcase
      end
   end
   assign reg_rdata_o = rdata_reg;

   // pin levels and enables
   // RULE_15 pin level follows the current bit
   assign serial_out_pin_o = bit_order_select_reg ? tx_reg[7] : tx_reg[0];
   // RULE_23 pins serve the interface only when enabled
   assign serial_out_pin_oe_o = serial_port_enable_reg;
   assign shift_clk_o = sclk_reg;
   assign shift_clk_oe_o = serial_port_enable_reg & master;
   // RULE_24 ready low while a slave transfer runs
   assign slave_ready_out_n_o = ~(running & ~master);
   assign slave_ready_out_oe_o = serial_port_enable_reg & ~master;
   assign rx_pin_pullup_o = pullup_reg[BIT_PU_RX];
   // clock pull-up only matters when the partner drives the clock
   assign clock_pin_pullup_o = pullup_reg[BIT_PU_CLK] & ~master;
   assign serial_port_enable_o = serial_port_enable_reg;
   // RULE_25 request from flag and enable
   assign serial_irq_o = serial_irq_flag_reg & serial_irq_enable_reg;
endmodule // csi_top

// *** test/csi_peer.sv ***
// far-end serial peer: slow clock in slave mode, byte exchange
`timescale 1ns/1ps
module csi_peer (
   input wire logic mclk_i,
   input wire logic go_i,
   input wire logic mst_i,
   input wire logic sclk_i,
   input wire logic serial_out_pin_i,
   input wire logic [7:0] tx_i,
   output logic sclk_o = 1'b1,
   output logic sin_o = 1'b1,
   output logic [7:0] rx_o
);
   logic act = 1'b0;
   logic prev = 1'b1;
   logic [4:0] h = 5'h0;
   logic [3:0] e = 4'h0;
   logic [2:0] idx = 3'h0;
   // 40 mclk period, started only by go
   always @(posedge mclk_i) begin
      if (go_i) begin
         // the peer drives the clock only when the block is slave
         act <= !mst_i;
         h <= 5'h0;
         e <= 4'h0;
         sclk_o <= mst_i;
      end else if (act) begin
         h <= (h == 5'd19) ? 5'h0 : h + 5'h1;
         if (h == 5'd19) begin
            sclk_o <= ~sclk_o;
            e <= e + 4'h1;
            act <= e != 4'd14;
         end
      end
   end
   // drive on falling edge, capture on rising
   always @(posedge mclk_i) begin
      prev <= sclk_i;
      if (go_i) begin
         idx <= 3'h0;
         sin_o <= 1'b1;
      end else if (prev && !sclk_i) begin
         sin_o <= tx_i[idx];
         idx <= idx + 3'h1;
      end else if (!prev && sclk_i) begin
         rx_o <= {serial_out_pin_i, rx_o[7:1]};
      end
   end
endmodule // csi_peer

// *** test/csi_top_properties.sv ***
// port assertions for the clocked serial interface
`timescale 1ns/1ps
module csi_top_checker
   import csi_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [3:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [3:0] reg_rdata_o,
   input wire logic low_speed_osc_edge_i,
   input wire logic timer_uf_i,
   input wire logic shift_clk_o,
   input wire logic shift_clk_oe_o,
   input wire logic slave_ready_out_n_o,
   input wire logic slave_ready_out_oe_o,
   input wire logic clock_pin_pullup_o,
   input wire logic serial_port_enable_o,
   input wire logic serial_out_pin_oe_o,
   input wire logic serial_irq_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   logic trig_w;
   // trigger write seen on the bus
   assign trig_w = reg_wr_i && reg_addr_i == ADDR_TRIG &&
      reg_wdata_i[BIT_TRIGGER];
   sequence flag_clr;
      reg_wr_i && reg_addr_i == ADDR_IRQ_FLAG && reg_wdata_i[BIT_IRQ];
   endsequence
   sequence mask_wr;
      reg_wr_i && reg_addr_i == ADDR_IRQ_EN && !reg_wdata_i[BIT_IRQ];
   endsequence
   a_rdata_idle: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == 4'h0) else $error("stray rdata");
   a_unmapped_zero: assert property (
      reg_rd_i && reg_addr_i[15:4] == 12'hff6 |=> reg_rdata_o == 4'h0)
      else $error("unmapped read not zero");
   a_clear_drops_irq: assert property (
      flag_clr |=> !serial_irq_o) else $error("flag clear kept irq");
   a_mask_blocks_irq: assert property (
      mask_wr |=> !serial_irq_o) else $error("masked irq raised");
   a_modes_exclusive: assert property (
      !(slave_ready_out_oe_o && shift_clk_oe_o)) else $error("both modes");
   a_clk_follows_tick: assert property (
      $changed(shift_clk_o) |-> $past(low_speed_osc_edge_i) || $past(timer_uf_i))
      else $error("master clock moved without tick");
   a_ready_after_trig: assert property (
      $fell(slave_ready_out_n_o) |-> $past(trig_w) || $past(trig_w, 2))
      else $error("ready without trigger");
   a_pullup_slave_only: assert property (
      clock_pin_pullup_o |-> !shift_clk_oe_o) else $error("pullup in master");
   a_oe_port: assert property (
      serial_out_pin_oe_o == serial_port_enable_o) else $error("oe mismatch");
endmodule // csi_top_checker

// *** test/tb_top.sv ***
// self-checking bench for the clocked serial interface
`timescale 1ns/1ps
module tb_top;
   import csi_pkg::*;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [3:0] reg_wdata_i = 4'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic low_speed_osc_edge_i = 1'b0;
   logic timer_uf_i = 1'b0;
   logic go = 1'b0;
   logic ien = 1'b0;
   logic [7:0] ptx = 8'h00;
   logic [3:0] reg_rdata_o, v;
   logic serial_out_pin_o, serial_out_pin_oe_o, shift_clk_o, shift_clk_oe_o;
   logic slave_ready_out_n_o, slave_ready_out_oe_o, rx_pin_pullup_o;
   logic clock_pin_pullup_o, serial_port_enable_o, serial_irq_o;
   logic p_sclk, p_sin, sclk, serial_out_pin;
   logic [7:0] prx;
   logic [2:0] ph = 3'h0;
   int errors = 0;
   int num_checks = 0;
   int cyc = 0;
   // shared pins: clock from block or peer, serial out pulled high when undriven
   assign sclk = shift_clk_oe_o ? shift_clk_o : p_sclk;
   assign serial_out_pin = serial_out_pin_oe_o ? serial_out_pin_o : 1'b1;
   always #12.5 mclk_i = ~mclk_i;
   csi_top u_csi_top (.mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .low_speed_osc_edge_i, .timer_uf_i,
      .serial_in_pin_i(p_sin), .serial_out_pin_o, .serial_out_pin_oe_o,
      .shift_clk_i(sclk), .shift_clk_o, .shift_clk_oe_o, .slave_ready_out_n_o,
      .slave_ready_out_oe_o, .rx_pin_pullup_o, .clock_pin_pullup_o,
      .serial_port_enable_o, .serial_irq_o);
   csi_peer u_csi_peer (.mclk_i, .go_i(go), .mst_i(shift_clk_oe_o),
      .sclk_i(sclk), .serial_out_pin_i(serial_out_pin),
      .tx_i(ptx), .sclk_o(p_sclk), .sin_o(p_sin), .rx_o(prx));
   // source ticks and a hang limit well past the longest run
   always @(posedge mclk_i) begin
      ph <= ph + 3'h1;
      low_speed_osc_edge_i <= ph[1:0] == 2'h3;
      timer_uf_i <= ph == 3'h5;
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         errors++;
         close_out();
      end
   end
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
      num_checks++;
      if (s !== x) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [3:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      // let the written state settle before outputs are looked at
      #1;
   endtask
   task automatic rd(input logic [15:0] a);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 v = reg_rdata_o;
   endtask
   function automatic logic [7:0] ord(input logic [7:0] b, input logic m);
      ord = m ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} : b;
   endfunction
   // one full byte exchange in mode m, peer sending the inverse
   task automatic xfer(input logic [3:0] m, input logic [7:0] d);
      logic [7:0] r;
      logic [7:0] x;
      logic sl;
      int n;
      sl = m[1:0] == CSS_EXTERNAL;
      wr(ADDR_MODE, m);
      chk("clk oe", {7'h0, shift_clk_oe_o}, {7'h0, m[1:0] != 2'h0});
      chk("slave_ready_out oe", {7'h0, slave_ready_out_oe_o}, {7'h0, sl});
      chk("clk pullup", {7'h0, clock_pin_pullup_o}, {7'h0, sl});
      wr(ADDR_DATA_LO, d[3:0]);
      wr(ADDR_DATA_HI, d[7:4]);
      ptx <= ~d;
      go <= m[1:0] != CSS_EXTERNAL;
      // port on, data touched, one trigger
      wr(ADDR_TRIG, 4'h3);
      go <= m[1:0] == CSS_EXTERNAL;
      @(posedge mclk_i);
      go <= 1'b0;
      rd(ADDR_TRIG);
      chk("run status", {4'h0, v}, 8'h03);
      if (m[1:0] == CSS_EXTERNAL) begin
         chk("ready", {7'h0, slave_ready_out_n_o}, 8'h00);
      end
      n = 0;
      while (v[1] === 1'b1 && n < 500) begin
         rd(ADDR_TRIG);
         n++;
      end
      chk("stop status", {4'h0, v}, 8'h01);
      chk("peer byte", prx, ord(d, m[3]));
      rd(ADDR_DATA_LO);
      r[3:0] = v;
      rd(ADDR_DATA_HI);
      r[7:4] = v;
      // falling-edge capture sees the bit before the peer moves it
      x = m[2] ? {~d[6:0], 1'b1} : ~d;
      chk("rx byte", r, ord(x, m[3]));
      rd(ADDR_IRQ_FLAG);
      chk("flag", {4'h0, v}, 8'h01);
      chk("irq out", {7'h0, serial_irq_o}, {7'h0, ien});
      wr(ADDR_IRQ_FLAG, 4'h0);
      chk("irq held", {7'h0, serial_irq_o}, {7'h0, ien});
      wr(ADDR_IRQ_FLAG, 4'h1);
      rd(ADDR_IRQ_FLAG);
      chk("flag clear", {4'h0, v}, 8'h00);
   endtask
   task automatic t_reset();
      logic [15:0] a [6];
      a = '{ADDR_PULLUP, ADDR_TRIG, ADDR_MODE, ADDR_IRQ_EN, ADDR_IRQ_FLAG,
         16'hff60};
      for (int i = 0; i < 6; i++) begin
         rd(a[i]);
         chk("reset", {4'h0, v}, {4'h0, i == 0 ? RST_PULLUP : READ_ZERO});
      end
      chk("clk pullup", {7'h0, clock_pin_pullup_o}, 8'h01);
      wr(ADDR_PULLUP, 4'h0);
      chk("rx pullup", {7'h0, rx_pin_pullup_o}, 8'h00);
      wr(ADDR_PULLUP, RST_PULLUP);
      $display("reset test done");
   endtask
   task automatic t_master();
      wr(ADDR_TRIG, 4'h1);
      chk("serial_out_pin oe", {7'h0, serial_out_pin_oe_o}, 8'h01);
      xfer(4'h3, 8'h5a);
      xfer(4'ha, 8'h3c);
      xfer(4'h7, 8'h69);
      wr(ADDR_IRQ_EN, 4'h1);
      ien = 1'b1;
      xfer(4'h1, 8'hc3);
      wr(ADDR_IRQ_EN, 4'h0);
      ien = 1'b0;
      $display("master test done");
   endtask
   task automatic t_slave();
      xfer(4'h8, 8'h96);
      xfer(4'h0, 8'h21);
      $display("slave test done");
   endtask
   task automatic t_arm();
      int n;
      wr(ADDR_TRIG, 4'h1);
      rd(ADDR_TRIG);
      chk("zero trigger", {4'h0, v}, 8'h01);
      wr(ADDR_MODE, {2'b00, CSS_LOW_SPEED_OSC});
      wr(ADDR_TRIG, 4'h3);
      rd(ADDR_TRIG);
      chk("armed trigger", {4'h0, v}, 8'h03);
      n = 0;
      while (v[1] === 1'b1 && n < 100) begin
         rd(ADDR_TRIG);
         n++;
      end
      wr(ADDR_TRIG, 4'h3);
      rd(ADDR_TRIG);
      chk("unarmed trigger", {4'h0, v}, 8'h01);
      $display("arming test done");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_master();
      t_slave();
      t_arm();
      close_out();
   end
endmodule // tb_top
bind csi_top csi_top_checker u_csi_top_checker (.mclk_i, .sys_rst_i,
   .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
   .low_speed_osc_edge_i, .timer_uf_i, .shift_clk_o, .shift_clk_oe_o,
   .slave_ready_out_n_o, .slave_ready_out_oe_o, .clock_pin_pullup_o,
   .serial_port_enable_o, .serial_out_pin_oe_o, .serial_irq_o);
